// ==== core/bit_set_call_pkg.sv ====
/*
  constants, offsets and types for the bit test-set and direct call executor.
  assumes a 32-bit avalon-mm master and one core clock.
*/
package bit_set_call_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INSTR1 = 8'h04;
  localparam logic [7:0] OFS_INSTR2 = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [7:0] OFS_PC     = 8'h14;
  localparam logic [7:0] OFS_PAGE   = 8'h18;
  localparam logic [7:0] OFS_WSEL   = 8'h1C;
  localparam logic [7:0] OFS_WDATA  = 8'h20;
  localparam logic [7:0] OFS_MADDR  = 8'h24;
  localparam logic [7:0] OFS_MDATA  = 8'h28;
  localparam logic [7:0] OFS_LASTEA = 8'h2C;
  // ==========================================================
  // field positions
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_EXT_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_ILL_BIT   = 1;
  localparam int FLAG_C_BIT     = 0;
  localparam int FLAG_Z_BIT     = 1;
  // ==========================================================
  // opcodes and addressing modes
  localparam logic [7:0] OPC_FILE_SET = 8'hAC;
  localparam logic [7:0] OPC_WREG_SET = 8'hA4;
  localparam logic [7:0] OPC_CALL     = 8'h02;
  localparam logic [2:0] MODE_DIRECT  = 3'h0;
  localparam logic [2:0] MODE_IND     = 3'h1;
  localparam logic [2:0] MODE_POSTDEC = 3'h2;
  localparam logic [2:0] MODE_POSTINC = 3'h3;
  localparam logic [2:0] MODE_PREDEC  = 3'h4;
  localparam logic [2:0] MODE_PREINC  = 3'h5;
  // ==========================================================
  // steps, sizes and reset values
  localparam logic [23:0] RET_STEP   = 24'h000004;
  localparam logic [23:0] INSTR_STEP = 24'h000002;
  localparam logic [15:0] PTR_STEP   = 16'h0002;
  localparam logic [3:0]  SP_INDEX   = 4'hF;
  localparam int          NUM_WREG   = 16;
  localparam int          DMEM_WORDS = 4096;
  localparam logic [15:0] FLAGS_RST  = 16'h0000;
  localparam logic [15:0] WREG_RST   = 16'h0000;
  localparam logic [23:0] PC_RST     = 24'h000000;
  localparam logic [9:0]  PAGE_RST   = 10'h000;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PUSH_HI} exec_state_type;
  typedef enum logic [1:0] {OP_FILE_SET, OP_WREG_SET, OP_CALL, OP_BAD} op_type;
endpackage : bit_set_call_pkg

// ==== core/bit_set_call_exec.sv ====
/*
  executor for the file and working-register test-set forms and the direct call,
  with its own working registers, flag register, program counter and data memory.
  assumes a synchronous avalon-mm master on CLK_SYS and a synchronous active-low reset.
*/
//
// Overview of operation
// - file form: Z gets inverse bit, then set bit
// - file address 0..8191 byte, even word
// - bit index from lsb, 7 byte, 15 word
// - file form opcode 1010 1100 decoded
// - byte suffix gives byte, else word (code has no byte form, file form is word only)
// - wreg form: C gets bit or Z inverse
// - wreg form word only, default Z option
// - wreg form opcode 1010 0100 field order
// - six addressing modes through source register
// - indirect address uses data read page
// - call pushes pc plus four, sp plus four
// - pc loads 23-bit target after stacking
// - call is two words with fixed fields
`timescale 1ns/1ps
module bit_set_call_exec
  import bit_set_call_pkg::*;
(
  // clock, reset, enable
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        CLK_EN,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);
  // ==========================================================
  // state
  logic [15:0]    wreg [NUM_WREG];
  logic [15:0]    dmem [DMEM_WORDS];
  logic [23:0]    instr1;
  logic [23:0]    instr2;
  logic [23:0]    pc;
  logic [23:0]    last_ea;
  logic [15:0]    flags;
  logic [9:0]     page;
  logic           ext_en;
  logic [3:0]     wsel;
  logic [12:0]    maddr;
  logic           illegal;
  exec_state_type state;
  op_type         op;
  logic           take_wr;
  logic           accept;
  logic [31:0]    rd_mux;
  // ==========================================================
  // decode
  function automatic op_type decode_op(input logic [23:0] w1, input logic [23:0] w2);
    if (w1[23:16] == OPC_FILE_SET)
      return OP_FILE_SET;
    if (w1[23:16] == OPC_WREG_SET && w1[10:7] == 4'h0 && w1[6:4] <= MODE_PREINC)
      return OP_WREG_SET;
    if (w1[23:16] == OPC_CALL && !w1[0] && w2[23:7] == 17'h00000)
      return OP_CALL;
    return OP_BAD;
  endfunction : decode_op

  // ==========================================================
  // operand fields
  logic [3:0]  file_bit;
  logic [11:0] file_idx;
  logic [3:0]  wreg_bit;
  logic [3:0]  src;
  logic [2:0]  mode;
  logic        csel;
  logic [15:0] ptr;
  logic [15:0] sp;
  logic [15:0] ea16;
  logic [15:0] ptr_new;
  logic [23:0] eff_addr;
  logic [23:0] ret;
  logic [22:0] lit;
  assign op       = decode_op(instr1, instr2);
  assign file_bit = {instr1[15:13], instr1[0]};
  assign file_idx = instr1[12:1];
  assign wreg_bit = instr1[15:12];
  assign csel     = instr1[11];
  assign mode     = instr1[6:4];
  assign src      = instr1[3:0];
  assign ptr      = wreg[src];
  assign sp       = wreg[SP_INDEX];
  assign ret      = pc + RET_STEP;
  assign lit      = {instr2[6:0], instr1[15:1], 1'b0};
  always_comb begin
    ea16    = ptr;
    ptr_new = ptr;
    case (mode)
      MODE_POSTINC: ptr_new = ptr + PTR_STEP;
      MODE_POSTDEC: ptr_new = ptr - PTR_STEP;
      MODE_PREINC: begin
        ea16    = ptr + PTR_STEP;
        ptr_new = ea16;
      end
      MODE_PREDEC: begin
        ea16    = ptr - PTR_STEP;
        ptr_new = ea16;
      end
      default: ptr_new = ptr;
    endcase
    if (ext_en && ea16[15])
      eff_addr = {page[8:0], ea16[14:0]};
    else
      eff_addr = {8'h00, ea16};
  end
  // ==========================================================
  // execution datapath
  logic        next_mem_we;
  logic [11:0] next_mem_idx;
  logic [15:0] next_mem_data;
  logic        next_w_we;
  logic [3:0]  next_w_idx;
  logic [15:0] next_w_data;
  logic        test_bit;
  logic [15:0] operand;
  always_comb begin
    next_mem_we   = 1'b0;
    next_mem_idx  = 12'h000;
    next_mem_data = 16'h0000;
    next_w_we     = 1'b0;
    next_w_idx    = 4'h0;
    next_w_data   = 16'h0000;
    test_bit      = 1'b0;
    operand       = 16'h0000;
    case (state)
      ST_EXEC: begin
        case (op)
          OP_FILE_SET: begin
            operand       = dmem[file_idx];
            test_bit      = operand[file_bit];
            next_mem_we   = 1'b1;
            next_mem_idx  = file_idx;
            next_mem_data = operand | 16'(16'h0001 << file_bit);
          end
          OP_WREG_SET: begin
            if (mode == MODE_DIRECT) begin
              operand     = ptr;
              next_w_we   = 1'b1;
              next_w_idx  = src;
              next_w_data = ptr | 16'(16'h0001 << wreg_bit);
            end else begin
              operand       = dmem[eff_addr[12:1]];
              next_mem_we   = 1'b1;
              next_mem_idx  = eff_addr[12:1];
              next_mem_data = operand | 16'(16'h0001 << wreg_bit);
              next_w_we     = (mode != MODE_IND);
              next_w_idx    = src;
              next_w_data   = ptr_new;
            end
            test_bit = operand[wreg_bit];
          end
          OP_CALL: begin
            next_mem_we   = 1'b1;
            next_mem_idx  = sp[12:1];
            next_mem_data = ret[15:0];
            next_w_we     = 1'b1;
            next_w_idx    = SP_INDEX;
            next_w_data   = sp + PTR_STEP;
          end
          default: next_mem_we = 1'b0;
        endcase
      end
      ST_PUSH_HI: begin
        next_mem_we   = 1'b1;
        next_mem_idx  = sp[12:1];
        next_mem_data = {8'h00, ret[23:16]};
        next_w_we     = 1'b1;
        next_w_idx    = SP_INDEX;
        next_w_data   = sp + PTR_STEP;
      end
      default: next_mem_we = 1'b0;
    endcase
  end
  // ==========================================================
  // sequencer
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      state <= ST_IDLE;
    end else if (CLK_EN) begin
      case (state)
        ST_IDLE: begin
          if (take_wr && AVS_ADDRESS == OFS_CTRL && AVS_WRITEDATA[CTRL_GO_BIT])
            state <= ST_EXEC;
        end
        ST_EXEC: state <= (op == OP_CALL) ? ST_PUSH_HI : ST_IDLE;
        ST_PUSH_HI: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // data memory
  always_ff @(posedge CLK_SYS) begin
    if (CLK_EN) begin
      if (next_mem_we)
        dmem[next_mem_idx] <= next_mem_data;
      else if (take_wr && AVS_ADDRESS == OFS_MDATA)
        dmem[maddr[12:1]] <= AVS_WRITEDATA[15:0];
    end
  end

  // ==========================================================
  // working registers
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      for (int i = 0; i < NUM_WREG; i++)
        wreg[i] <= WREG_RST;
    end else if (CLK_EN) begin
      if (next_w_we)
        wreg[next_w_idx] <= next_w_data;
      else if (take_wr && AVS_ADDRESS == OFS_WDATA)
        wreg[wsel] <= AVS_WRITEDATA[15:0];
    end
  end

  // ==========================================================
  // flags, program counter, illegal status
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      flags <= FLAGS_RST;
    end else if (CLK_EN) begin
      if (state == ST_EXEC && op == OP_FILE_SET)
        flags[FLAG_Z_BIT] <= ~test_bit;
      else if (state == ST_EXEC && op == OP_WREG_SET && csel)
        flags[FLAG_C_BIT] <= test_bit;
      else if (state == ST_EXEC && op == OP_WREG_SET)
        flags[FLAG_Z_BIT] <= ~test_bit;
      else if (take_wr && AVS_ADDRESS == OFS_FLAGS)
        flags <= AVS_WRITEDATA[15:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pc <= PC_RST;
    end else if (CLK_EN) begin
      if (state == ST_PUSH_HI)
        pc <= {1'b0, lit};
      else if (state == ST_EXEC && (op == OP_FILE_SET || op == OP_WREG_SET))
        pc <= pc + INSTR_STEP;
      else if (take_wr && AVS_ADDRESS == OFS_PC)
        pc <= AVS_WRITEDATA[23:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      illegal <= 1'b0;
      last_ea <= 24'h000000;
    end else if (CLK_EN) begin
      if (state == ST_EXEC && op == OP_BAD)
        illegal <= 1'b1;
      else if (take_wr && AVS_ADDRESS == OFS_STATUS && AVS_WRITEDATA[STAT_ILL_BIT])
        illegal <= 1'b0;
      if (state == ST_EXEC && op == OP_WREG_SET && mode != MODE_DIRECT)
        last_ea <= eff_addr;
    end
  end

  // ==========================================================
  // software-written configuration
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      instr1 <= 24'h000000;
      instr2 <= 24'h000000;
      page   <= PAGE_RST;
      ext_en <= 1'b0;
      wsel   <= 4'h0;
      maddr  <= 13'h0000;
    end else if (CLK_EN && take_wr) begin
      case (AVS_ADDRESS)
        OFS_CTRL:   ext_en <= AVS_WRITEDATA[CTRL_EXT_BIT];
        OFS_INSTR1: instr1 <= AVS_WRITEDATA[23:0];
        OFS_INSTR2: instr2 <= AVS_WRITEDATA[23:0];
        OFS_PAGE:   page   <= AVS_WRITEDATA[9:0];
        OFS_WSEL:   wsel   <= AVS_WRITEDATA[3:0];
        OFS_MADDR:  maddr  <= AVS_WRITEDATA[12:0];
        default:    wsel   <= wsel;
      endcase
    end
  end

  // ==========================================================
  // avalon-mm slave
  assign accept  = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && state == ST_IDLE;
  assign take_wr = AVS_WRITE && !AVS_WAITREQUEST;
  always_comb begin
    case (AVS_ADDRESS)
      OFS_CTRL:   rd_mux = {30'h0, ext_en, 1'b0};
      OFS_INSTR1: rd_mux = {8'h00, instr1};
      OFS_INSTR2: rd_mux = {8'h00, instr2};
      OFS_STATUS: rd_mux = {30'h0, illegal, state != ST_IDLE};
      OFS_FLAGS:  rd_mux = {16'h0000, flags};
      OFS_PC:     rd_mux = {8'h00, pc};
      OFS_PAGE:   rd_mux = {22'h0, page};
      OFS_WSEL:   rd_mux = {28'h0, wsel};
      OFS_WDATA:  rd_mux = {16'h0000, wreg[wsel]};
      OFS_MADDR:  rd_mux = {19'h0, maddr};
      OFS_MDATA:  rd_mux = {16'h0000, dmem[maddr[12:1]]};
      OFS_LASTEA: rd_mux = {8'h00, last_ea};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else if (CLK_EN) begin
      AVS_WAITREQUEST <= !accept;
      if (accept && AVS_READ)
        AVS_READDATA <= rd_mux;
    end
  end

  // ==========================================================
  // assertions
  default clocking dflt @(posedge CLK_SYS iff CLK_EN); endclocking
  default disable iff (!RSTN);
  wire exec_file = state == ST_EXEC && op == OP_FILE_SET;
  wire exec_wreg = state == ST_EXEC && op == OP_WREG_SET;
  wire exec_call = state == ST_EXEC && op == OP_CALL;
  a_file_zero_flag: assert property (exec_file |=> flags[FLAG_Z_BIT] == !$past(test_bit))
    else $error("file form zero flag wrong");
  a_file_bit_set: assert property (exec_file |=> dmem[$past(file_idx)][$past(file_bit)])
    else $error("file form bit not set");
  a_wreg_carry: assert property (exec_wreg && csel |=> flags[FLAG_C_BIT] == $past(test_bit)
    && $stable(flags[FLAG_Z_BIT]))
    else $error("carry option flag wrong");
  a_wreg_default_z: assert property (exec_wreg && !csel |=> flags[FLAG_Z_BIT] == !$past(test_bit)
    && $stable(flags[FLAG_C_BIT]))
    else $error("zero option flag wrong");
  a_ptr_step_two: assert property (exec_wreg && mode == MODE_POSTINC
    |=> wreg[$past(src)] == $past(ptr) + PTR_STEP)
    else $error("pointer did not step by two");
  a_call_two_cycles: assert property (exec_call |=> state == ST_PUSH_HI ##1 state == ST_IDLE)
    else $error("call did not take two cycles");
  a_call_stack_push: assert property (exec_call |=> ##1 sp == $past(sp, 2) + 16'h0004
    && dmem[$past(sp[12:1], 2)] == $past(ret[15:0], 2))
    else $error("call stack push wrong");
  a_call_target_pc: assert property (exec_call |=> ##1 pc == {1'b0, $past(lit, 2)})
    else $error("call target not loaded");
  a_call_flags_kept: assert property (exec_call |=> $stable(flags) [*2])
    else $error("call changed flags");
  a_bad_opcode: assert property (state == ST_EXEC && op == OP_BAD |=> illegal && state == ST_IDLE)
    else $error("bad opcode not flagged");
  a_bus_answer: assert property (accept |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not one cycle");
  c_file_set: cover property (exec_file);
  c_wreg_pre_dec: cover property (exec_wreg && mode == MODE_PREDEC);
  c_call_done: cover property (exec_call ##2 state == ST_IDLE);
endmodule : bit_set_call_exec

// ==== tb/avalon_host_model.sv ====
/*
  avalon-mm host model standing in for software on the executor's register bus.
  assumes one rising-edge clock and a slave that answers with waitrequest low.
*/
`timescale 1ns/1ps
module avalon_host_model (
  // clock
  input  wire logic        clk,
  // bus to the slave
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  // ==========================================================
  // idle bus
  initial begin
    address   = 8'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0;
  end

  // ==========================================================
  // bus cycles: hold until waitrequest is low at a rising edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_read
endmodule : avalon_host_model

// ==== tb/tb_bit_set_call_exec.sv ====
/*
  self-checking testbench: runs every instruction form through the register bus.
  assumes the executor package and the avalon host model.
*/
`timescale 1ns/1ps
module tb_bit_set_call_exec
  import bit_set_call_pkg::*;
;
  // ==========================================================
  // signals and instances
  logic        clk_sys;
  logic        rstn;
  logic        clk_en;
  logic [7:0]  av_address;
  logic        av_read;
  logic        av_write;
  logic [31:0] av_writedata;
  logic [31:0] av_readdata;
  logic        av_waitrequest;
  int          mismatches;
  int          checks;

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  bit_set_call_exec DUT (
    .CLK_SYS(clk_sys), .RSTN(rstn), .CLK_EN(clk_en), .AVS_ADDRESS(av_address),
    .AVS_READ(av_read), .AVS_WRITE(av_write), .AVS_WRITEDATA(av_writedata),
    .AVS_READDATA(av_readdata), .AVS_WAITREQUEST(av_waitrequest)
  );

  avalon_host_model host (
    .clk(clk_sys), .address(av_address), .read(av_read), .write(av_write),
    .writedata(av_writedata), .readdata(av_readdata), .waitrequest(av_waitrequest)
  );

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] expv);
    checks++;
    if (got !== expv) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, expv);
    end
  endtask : check

  task automatic rd_check(input logic [7:0] a, input logic [31:0] expv);
    logic [31:0] d;
    host.bus_read(a, d);
    check(d, expv);
  endtask : rd_check

  task automatic set_w(input logic [3:0] i, input logic [15:0] v);
    host.bus_write(OFS_WSEL, {28'h0, i});
    host.bus_write(OFS_WDATA, {16'h0, v});
  endtask : set_w

  task automatic w_check(input logic [3:0] i, input logic [15:0] v);
    host.bus_write(OFS_WSEL, {28'h0, i});
    rd_check(OFS_WDATA, {16'h0, v});
  endtask : w_check

  task automatic set_m(input logic [12:0] a, input logic [15:0] v);
    host.bus_write(OFS_MADDR, {19'h0, a});
    host.bus_write(OFS_MDATA, {16'h0, v});
  endtask : set_m

  task automatic m_check(input logic [12:0] a, input logic [15:0] v);
    host.bus_write(OFS_MADDR, {19'h0, a});
    rd_check(OFS_MDATA, {16'h0, v});
  endtask : m_check

  task automatic run(input logic [23:0] i1, input logic [23:0] i2, input logic ext);
    logic [31:0] d;
    host.bus_write(OFS_INSTR1, {8'h00, i1});
    host.bus_write(OFS_INSTR2, {8'h00, i2});
    host.bus_write(OFS_CTRL, {30'h0, ext, 1'b1});
    for (int k = 0; k < 16; k++) begin
      host.bus_read(OFS_STATUS, d);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    check({31'h0, d[STAT_BUSY_BIT]}, 32'h0);
  endtask : run

  task automatic file_case(input logic [12:0] a, input logic [3:0] b, input logic [15:0] pre,
                           input logic [15:0] post, input logic [15:0] fl);
    set_m(a, pre);
    run({8'hAC, b[3:1], a[12:1], b[0]}, 24'h0, 1'b0);
    m_check(a, post);
    rd_check(OFS_FLAGS, {16'h0, fl});
  endtask : file_case

  task automatic wreg_case(input logic [3:0] s, input logic [3:0] b, input logic c,
                           input logic [15:0] pre, input logic [15:0] post,
                           input logic [15:0] fin, input logic [15:0] fout);
    set_w(s, pre);
    host.bus_write(OFS_FLAGS, {16'h0, fin});
    run({8'hA4, b, c, 4'h0, MODE_DIRECT, s}, 24'h0, 1'b0);
    w_check(s, post);
    rd_check(OFS_FLAGS, {16'h0, fout});
  endtask : wreg_case

  task automatic call_case(input logic [22:0] tgt, input logic [23:0] ret,
                           input logic [15:0] sp);
    run({8'h02, tgt[15:1], 1'b0}, {17'h0, tgt[22:16]}, 1'b0);
    m_check(sp[12:0], ret[15:0]);
    m_check(sp[12:0] + 13'h2, {8'h00, ret[23:16]});
    w_check(4'hF, sp + 16'h4);
    rd_check(OFS_PC, {9'h0, tgt});
    rd_check(OFS_FLAGS, 32'h3);
  endtask : call_case

  // ==========================================================
  // scenarios
  task automatic test_reset();
    rd_check(OFS_FLAGS, 32'h0);
    rd_check(OFS_PC, 32'h0);
    rd_check(OFS_STATUS, 32'h0);
    rd_check(OFS_PAGE, 32'h0);
    rd_check(8'h30, 32'h0);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_file();
    file_case(13'h1200, 4'hB, 16'hF7FF, 16'hFFFF, 16'h0002);
    file_case(13'h1200, 4'hB, 16'hFFFF, 16'hFFFF, 16'h0000);
    file_case(13'h1FFE, 4'hF, 16'h0000, 16'h8000, 16'h0002);
    file_case(13'h0000, 4'h0, 16'hFFFE, 16'hFFFF, 16'h0002);
    rd_check(OFS_PC, 32'h8);
    $display("test_file done");
  endtask : test_file

  task automatic test_direct();
    wreg_case(4'h0, 4'h7, 1'b0, 16'hF234, 16'hF2B4, 16'h0, 16'h2);
    wreg_case(4'h2, 4'h3, 1'b1, 16'h0008, 16'h0008, 16'h0, 16'h1);
    wreg_case(4'h3, 4'hF, 1'b1, 16'h0000, 16'h8000, 16'h3, 16'h2);
    wreg_case(4'h4, 4'h0, 1'b0, 16'h0001, 16'h0001, 16'h2, 16'h0);
    $display("test_direct done");
  endtask : test_direct

  task automatic test_modes();
    logic [15:0] dp;
    logic [15:0] de;
    for (int m = 1; m < 6; m++) begin
      dp = (m == 2 || m == 4) ? 16'hFFFE : (m == 3 || m == 5) ? 16'h0002 : 16'h0000;
      de = (m == 4) ? 16'hFFFE : (m == 5) ? 16'h0002 : 16'h0000;
      for (int j = 0; j < 3; j++) set_m(13'h11FE + 13'(2 * j), 16'h0);
      set_w(4'h5, 16'h1200);
      host.bus_write(OFS_FLAGS, 32'h1);
      run({8'hA4, 4'h4, 1'b1, 4'h0, m[2:0], 4'h5}, 24'h0, 1'b0);
      m_check(13'h1200 + de[12:0], 16'h0010);
      w_check(4'h5, 16'h1200 + dp);
      rd_check(OFS_FLAGS, 32'h0);
    end
    $display("test_modes done");
  endtask : test_modes

  task automatic test_page();
    set_m(13'h0200, 16'h0);
    set_w(4'h6, 16'h8200);
    host.bus_write(OFS_PAGE, 32'h00A);
    run({8'hA4, 4'h0, 1'b0, 4'h0, MODE_IND, 4'h6}, 24'h0, 1'b1);
    rd_check(OFS_LASTEA, 32'h00050200);
    m_check(13'h0200, 16'h0001);
    rd_check(OFS_CTRL, 32'h2);
    $display("test_page done");
  endtask : test_page

  task automatic test_call();
    host.bus_write(OFS_PC, 32'h026000);
    host.bus_write(OFS_FLAGS, 32'h3);
    set_w(4'hF, 16'h1268);
    call_case(23'h026844, 24'h026004, 16'h1268);
    call_case(23'h7FFFFE, 24'h026848, 16'h126C);
    $display("test_call done");
  endtask : test_call

  task automatic test_illegal();
    logic [23:0] i1;
    logic [23:0] i2;
    for (int k = 0; k < 3; k++) begin
      i2 = (k == 2) ? 24'h000080 : 24'h0;
      i1 = (k == 0) ? 24'hFF0000 : (k == 1) ? {8'hA4, 9'h0, 3'h6, 4'h0} : 24'h020000;
      host.bus_write(OFS_STATUS, 32'h2);
      rd_check(OFS_STATUS, 32'h0);
      run(i1, i2, 1'b0);
      rd_check(OFS_STATUS, 32'h2);
      rd_check(OFS_PC, 32'h7FFFFE);
    end
    host.bus_write(OFS_LASTEA, 32'h0);
    rd_check(OFS_LASTEA, 32'h00050200);
    $display("test_illegal done");
  endtask : test_illegal

  task automatic test_freeze();
    time t0;
    host.bus_write(OFS_PC, 32'h00000100);
    t0 = $time;
    fork
      begin
        @(posedge clk_sys);
        clk_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        clk_en <= 1'b1;
      end
      rd_check(OFS_PC, 32'h00000100);
    join
    check(32'(($time - t0) / 8), 32'h00000007);
    $display("test_freeze done");
  endtask : test_freeze

  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (30000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end

  initial begin
    mismatches = 0;
    checks     = 0;
    clk_en     = 1'b1;
    rstn       = 1'b0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    test_reset();
    test_file();
    test_direct();
    test_modes();
    test_page();
    test_call();
    test_illegal();
    test_freeze();
    print_verdict();
  end
endmodule : tb_bit_set_call_exec
